// file: rtl/srt_timer.sv
/*
  Sixteen-bit reload timer with a classic Wishbone register slave.
  Continuous mode counts prescaled clk_sys; counter mode counts qualified pin edges.
  Assumes one clock, clk_sys, and a timer input pin driven by a GPIO alternate function.
  Assumes software sets up count, reload and control before setting the enable bit.
  Interrupt routing and priority live outside; only a one-cycle request leaves here.
*/
// Function
// - Continuous passes after reload start at one
// - Continuous mode counts prescaled system clock
// - Period equals reload times 2^prescale over clock
// - Loaded start value governs first pass only
// - Counter mode counts timer input transitions
// - Polarity bit picks rising or falling edge
// - Counter mode bypasses prescaler
// - At reload: request, restart at one, continue
// - Output pin toggles at every reload
// - First edge starts counting, no request
// - Capture time from count difference and prescale
// - Count reads never disturb counting
// - High byte read latches low byte
// - Disabled low byte read returns live count
// - Byte write lands at next edge
// - Count is two visible byte registers
`timescale 1ns/1ps
module srt_timer (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // Wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [srt_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  // Timer pins
  input  wire logic                   tmr_in,
  output logic                        tmr_out,
  output logic                        tmr_out_en,
  // Reload event
  output logic                        tmr_irq
);
  import srt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  // Registers end in _reg, next values in _next, decoded nets in _w
  srt_wb_req_t        req_w;
  srt_ctrl_t          ctrl_reg;
  srt_state_t         state_reg;
  srt_state_t         state_next;
  logic [CNT_W-1:0]   count_reg;
  logic [CNT_W-1:0]   count_next;
  logic [CNT_W-1:0]   reload_reg;
  logic [7:0]         hold_reg;
  logic [PSC_W-1:0]   psc_reg;
  logic [PSC_W-1:0]   psc_next;
  logic               out_reg;
  logic               irq_reg;
  logic               reload_flag_reg;
  logic               ack_reg;
  logic [31:0]        rdata_reg;
  logic               edge_w;

  wire                access_w;
  wire                wr_w;
  wire                rd_w;
  wire                lane0_w;
  wire                wr_count_hi_w;
  wire                wr_count_lo_w;
  wire                wr_reload_hi_w;
  wire                wr_reload_lo_w;
  wire                wr_ctrl_w;
  wire                wr_status_w;
  wire                rd_count_hi_w;
  wire                running_w;
  wire [PSC_W-1:0]    psc_last_w;
  wire                psc_tc_w;
  wire                tick_w;
  wire                at_reload_w;
  wire [CNT_W-1:0]    count_inc_w;
  wire [7:0]          low_view_w;
  wire [7:0]          ctrl_bits_w;
  wire [7:0]          status_bits_w;
  wire [31:0]         rdata_w;

  ////////////////////////////////////////////////////////////////////////////
  // Address match, used by both read and write decode
  // Full-width compare, so no offset is aliased elsewhere in the map
  function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [7:0] ofs);
    hit = (adr == ofs[ADR_W-1:0]);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Bus request bundle
  // Carried as one packed struct so all decode reads a single bundle
  assign req_w = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                   sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};

  // Request is taken once, in the cycle before ack rises
  // Ack is registered; masking with it stops a held request being taken twice
  assign access_w = req_w.cyc & req_w.stb & ~ack_reg;
  assign wr_w     = access_w & req_w.we;
  assign rd_w     = access_w & ~req_w.we;
  assign lane0_w  = req_w.sel[0];

  // Write strobes; data lives in byte lane 0
  // Lane 0 off or an unmapped offset leaves every register untouched
  assign wr_count_hi_w  = wr_w & lane0_w & hit(req_w.adr, OFS_COUNT_HIGH);
  assign wr_count_lo_w  = wr_w & lane0_w & hit(req_w.adr, OFS_COUNT_LOW);
  assign wr_reload_hi_w = wr_w & lane0_w & hit(req_w.adr, OFS_RELOAD_HI);
  assign wr_reload_lo_w = wr_w & lane0_w & hit(req_w.adr, OFS_RELOAD_LO);
  assign wr_ctrl_w      = wr_w & lane0_w & hit(req_w.adr, OFS_CONTROL);
  assign wr_status_w    = wr_w & lane0_w & hit(req_w.adr, OFS_STATUS);
  assign rd_count_hi_w  = rd_w & hit(req_w.adr, OFS_COUNT_HIGH);

  ////////////////////////////////////////////////////////////////////////////
  // Input conditioner for counter mode
  // Pin is asynchronous to clk_sys; toggling faster than clk/4 is not supported
  srt_edge u_edge (
    .clk_sys              (clk_sys),
    .rst                  (rst),
    .pin_in               (tmr_in),
    .edge_polarity_select (ctrl_reg.edge_polarity_select),
    .edge_pulse           (edge_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Tick source selection
  // Prescaler divides by 2^prescale; counter mode never uses it
  // Pin path is two sync flops and the edge flop, so the count lags the pin by four
  assign running_w   = (state_reg == SRT_ST_RUN);
  assign psc_last_w  = PSC_W'((8'h01 << ctrl_reg.prescale) - 8'h01);
  assign psc_tc_w    = (psc_reg == psc_last_w);
  assign tick_w      = running_w &
                       (ctrl_reg.counter_mode ? edge_w
                                              : psc_tc_w);

  // Compare on the current count in the tick cycle
  // Equality only: a count written past reload runs on and wraps through zero
  assign at_reload_w = (count_reg == reload_reg);
  assign count_inc_w = CNT_W'(count_reg + 16'h0001);

  // Prescaler runs only in continuous mode while running
  // Ticks are exactly 2^prescale cycles apart, so a count difference scales to time
  always_comb begin
    psc_next = psc_reg;
    if (!running_w || ctrl_reg.counter_mode || psc_tc_w) begin
      psc_next = '0;
    end else begin
      psc_next = PSC_W'(psc_reg + 7'h01);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run state: idle, armed for first edge, running
  // Counter mode parks in ARM until one qualifying edge; that edge only arms,
  // so it neither counts nor raises a request
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SRT_ST_IDLE: begin
        if (ctrl_reg.enable) begin
          state_next = ctrl_reg.counter_mode ? SRT_ST_ARM : SRT_ST_RUN;
        end
      end
      SRT_ST_ARM: begin
        if (!ctrl_reg.enable) begin
          state_next = SRT_ST_IDLE;
        end else if (edge_w) begin
          state_next = SRT_ST_RUN;
        end
      end
      SRT_ST_RUN: begin
        if (!ctrl_reg.enable) begin
          state_next = SRT_ST_IDLE;
        end
      end
      default: begin
        state_next = SRT_ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next count; a byte write overrides the tick in the same cycle
  // There is no write holding register: the other byte keeps its ticked value,
  // so a 16-bit write while running can be torn between the two bytes
  always_comb begin
    count_next = count_reg;
    if (tick_w) begin
      count_next = at_reload_w ? COUNT_RESTART
                               : count_inc_w;
    end
    if (wr_count_hi_w) begin
      count_next[15:8] = req_w.dat[7:0];
    end
    if (wr_count_lo_w) begin
      count_next[7:0] = req_w.dat[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, prescaler and state flops
  // Disabling keeps the count, so a stopped timer can be read and resumed
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= SRT_ST_IDLE;
      count_reg <= COUNT_RST_VAL;
      psc_reg   <= '0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      psc_reg   <= psc_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reload event: request pulse and output toggle
  // The level freezes while the output function is off, and resumes from there
  // The request is a single-cycle pulse; the status flag keeps the sticky copy
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_reg <= 1'b0;
      out_reg <= 1'b0;
    end else begin
      irq_reg <= tick_w & at_reload_w;
      if (tick_w && at_reload_w && ctrl_reg.out_en) begin
        out_reg <= ~out_reg;
      end
    end
  end

  // Sticky reload flag; a new reload beats a same-cycle clear
  // Software writes a one to clear it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reload_flag_reg <= 1'b0;
    end else if (tick_w && at_reload_w) begin
      reload_flag_reg <= 1'b1;
    end else if (wr_status_w && req_w.dat[STS_RELOAD_BIT]) begin
      reload_flag_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  // Settings change live; software is expected to set up before enabling
  // Bit 7 of the control byte is not stored and reads back as zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_reg   <= srt_ctrl_t'(CONTROL_RST[7-1:0]);
      reload_reg <= RELOAD_RST_VAL;
    end else begin
      if (wr_ctrl_w) begin
        ctrl_reg <= srt_ctrl_t'(req_w.dat[6:0]);
      end
      if (wr_reload_hi_w) begin
        reload_reg[15:8] <= req_w.dat[7:0];
      end
      if (wr_reload_lo_w) begin
        reload_reg[7:0] <= req_w.dat[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Coherent read holding register
  // Captured only by a high byte read while enabled; never touches the count
  // Reads sit off the count path entirely, so they cannot stall or skew counting
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hold_reg <= 8'h00;
    end else if (rd_count_hi_w && ctrl_reg.enable) begin
      hold_reg <= count_reg[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low byte view: held copy when enabled, live byte when disabled
  // A low read with no high read before it returns a stale held copy
  assign low_view_w = ctrl_reg.enable ? hold_reg
                                      : count_reg[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Control and status byte images
  // Status: sticky reload flag, run state, output level
  assign ctrl_bits_w   = {1'b0, ctrl_reg};
  assign status_bits_w = {5'h00, out_reg, running_w, reload_flag_reg};

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read zero
  // Only lane 0 carries data; the upper lanes always read zero
  assign rdata_w =
    hit(req_w.adr, OFS_COUNT_HIGH) ? {24'h000000, count_reg[15:8]} :
    hit(req_w.adr, OFS_COUNT_LOW)  ? {24'h000000, low_view_w}      :
    hit(req_w.adr, OFS_RELOAD_HI)  ? {24'h000000, reload_reg[15:8]} :
    hit(req_w.adr, OFS_RELOAD_LO)  ? {24'h000000, reload_reg[7:0]}  :
    hit(req_w.adr, OFS_CONTROL)    ? {24'h000000, ctrl_bits_w}      :
    hit(req_w.adr, OFS_STATUS)     ? {24'h000000, status_bits_w}    :
                                     32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: ack one cycle after the request, dropped the next cycle
  // Fixed single wait state; read data is registered and holds until the next read
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= access_w;
      if (rd_w) begin
        rdata_reg <= rdata_w;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pin enable follows the alternate function bit
  // Registered so the pin enable comes straight from a flop
  logic out_en_reg;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_en_reg <= 1'b0;
    end else begin
      out_en_reg <= ctrl_reg.out_en;
    end
  end

  // Outputs, all straight from flops
  assign wb_ack_o   = ack_reg;
  assign wb_dat_o   = rdata_reg;
  assign tmr_out    = out_reg;
  assign tmr_out_en = out_en_reg;
  assign tmr_irq    = irq_reg;

endmodule : srt_timer

// file: rtl/srt_pkg.sv
/*
  Constants and types shared by the reload timer design.
  Assumes a 32-bit classic Wishbone register bus, byte offsets in the map.
*/
package srt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam int unsigned ADR_W          = 8;
  localparam logic [7:0]  OFS_COUNT_HIGH = 8'h00;
  localparam logic [7:0]  OFS_COUNT_LOW  = 8'h04;
  localparam logic [7:0]  OFS_RELOAD_HI  = 8'h08;
  localparam logic [7:0]  OFS_RELOAD_LO  = 8'h0C;
  localparam logic [7:0]  OFS_CONTROL    = 8'h10;
  localparam logic [7:0]  OFS_STATUS     = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // Control field positions
  localparam int unsigned CTL_ENABLE_BIT = 0;
  localparam int unsigned CTL_MODE_BIT   = 1;
  localparam int unsigned CTL_POL_BIT    = 2;
  localparam int unsigned CTL_OUTEN_BIT  = 3;
  localparam int unsigned CTL_PRE_LSB    = 4;
  localparam int unsigned PRE_W          = 3;

  // Status field positions
  localparam int unsigned STS_RELOAD_BIT = 0;
  localparam int unsigned STS_RUN_BIT    = 1;
  localparam int unsigned STS_OUT_BIT    = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and reset values
  localparam int unsigned CNT_W          = 16;
  localparam int unsigned PSC_W          = 7;
  localparam logic [15:0] COUNT_RESTART  = 16'h0001;
  localparam logic [15:0] COUNT_RST_VAL  = 16'h0001;
  localparam logic [15:0] RELOAD_RST_VAL = 16'hFFFF;
  localparam logic [7:0]  CONTROL_RST    = 8'h00;
  localparam int unsigned SYNC_STAGES    = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    SRT_ST_IDLE = 3'b001,
    SRT_ST_ARM  = 3'b010,
    SRT_ST_RUN  = 3'b100
  } srt_state_t;

  typedef struct packed {
    logic [PRE_W-1:0] prescale;
    logic             out_en;
    logic             edge_polarity_select;
    logic             counter_mode;
    logic             enable;
  } srt_ctrl_t;

  typedef struct packed {
    logic                 cyc;
    logic                 stb;
    logic                 we;
    logic [3:0]           sel;
    logic [ADR_W-1:0]     adr;
    logic [31:0]          dat;
  } srt_wb_req_t;

endpackage : srt_pkg

// file: rtl/srt_edge.sv
/*
  Timer input conditioner: synchroniser and polarity-selected edge detector.
  Assumes the pin may be asynchronous and toggles at most at a quarter of clk_sys.
*/
`timescale 1ns/1ps
module srt_edge (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Pin side
  input  wire logic pin_in,
  input  wire logic edge_polarity_select,
  // Qualified edge, one-cycle pulse
  output logic      edge_pulse
);
  import srt_pkg::*;

  logic [SYNC_STAGES-1:0] sync_reg;
  logic                   last_reg;
  logic                   edge_pulse_reg;
  wire                    rise_w;
  wire                    fall_w;

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchroniser; only the last stage is looked at
  genvar g;
  generate
    for (g = 0; g < SYNC_STAGES; g++) begin : g_sync
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) sync_reg[g] <= 1'b0;
        else     sync_reg[g] <= (g == 0) ? pin_in : sync_reg[(g == 0) ? 0 : g-1];
      end
    end
  endgenerate

  // Edge qualifiers from the settled stage only
  assign rise_w = sync_reg[SYNC_STAGES-1] & ~last_reg;
  assign fall_w = ~sync_reg[SYNC_STAGES-1] & last_reg;

  // One pulse per qualifying edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      last_reg       <= 1'b0;
      edge_pulse_reg <= 1'b0;
    end else begin
      last_reg       <= sync_reg[SYNC_STAGES-1];
      edge_pulse_reg <= edge_polarity_select ? fall_w : rise_w;
    end
  end

  assign edge_pulse = edge_pulse_reg;

endmodule : srt_edge

// file: verif/srt_timer_monitor.sv
/* Checker for the reload timer, watching the ports of srt_timer only.
   Assumes one clock domain and bus writes that take effect at the taken edge. */
`timescale 1ns/1ps
module srt_timer_monitor
  import srt_pkg::*;
(
  // Clock and reset
  input wire logic                      clk_sys,
  input wire logic                      rst,
  // Register bus
  input wire logic                      wb_cyc_i,
  input wire logic                      wb_stb_i,
  input wire logic                      wb_we_i,
  input wire logic [3:0]                wb_sel_i,
  input wire logic [srt_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [31:0]               wb_dat_i,
  input wire logic [31:0]               wb_dat_o,
  input wire logic                      wb_ack_o,
  // Timer pins
  input wire logic                      tmr_in,
  input wire logic                      tmr_out,
  input wire logic                      tmr_out_en,
  input wire logic                      tmr_irq
);
  logic        take;
  logic        wr_take;
  logic        mapped;
  logic [7:0]  ctl_sh;
  logic [15:0] rel_sh;
  logic [31:0] gap;
  logic [31:0] period;
  logic        clean;
  logic [3:0]  pin_age;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode and expected period
  assign take    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_take = take && wb_we_i && wb_sel_i[0];
  assign mapped  = (wb_adr_i <= OFS_STATUS) && (wb_adr_i[1:0] == 2'h0);
  assign period  = {16'h0, rel_sh} << ctl_sh[6:4];

  // Shadow config; any lane 0 write spoils the next gap, reads must not
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctl_sh <= CONTROL_RST;
      rel_sh <= RELOAD_RST_VAL;
      gap    <= 32'h0;
      clean  <= 1'b0;
    end else begin
      gap   <= tmr_irq ? 32'h1 : gap + 32'h1;
      clean <= wr_take ? 1'b0 : (tmr_irq ? 1'b1 : clean);
      if (wr_take && wb_adr_i == OFS_CONTROL) ctl_sh <= wb_dat_i[7:0];
      if (wr_take && wb_adr_i == OFS_RELOAD_HI) rel_sh[15:8] <= wb_dat_i[7:0];
      if (wr_take && wb_adr_i == OFS_RELOAD_LO) rel_sh[7:0] <= wb_dat_i[7:0];
    end
  end

  // Cycles since the pin last moved, saturating
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) pin_age <= 4'hF;
    else if ($changed(tmr_in)) pin_age <= 4'h0;
    else if (pin_age != 4'hF) pin_age <= pin_age + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Bus handshake and read images, then reload timing and pin checks
  AST_ACK_NEXT: assert property (take |=> wb_ack_o) else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  AST_RD_UNMAPPED: assert property (wb_ack_o && !wb_we_i && !mapped |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_RD_RELOAD: assert property (wb_ack_o && !wb_we_i && wb_adr_i == OFS_RELOAD_LO
    |-> wb_dat_o == {24'h0, rel_sh[7:0]}) else $error("reload readback");
  AST_OUT_TOGGLE: assert property ($changed(tmr_out) |-> tmr_irq) else $error("output moved");
  AST_OUT_EN: assert property (tmr_out_en == $past(ctl_sh[3])) else $error("output enable");
  AST_PERIOD: assert property (tmr_irq && clean && ctl_sh[0] && !ctl_sh[1] |-> gap == period)
    else $error("reload period wrong");
  AST_CNT_EDGE: assert property (tmr_irq && ctl_sh[1] |-> pin_age < 4'd9)
    else $error("counter reload without input edge");

  // Main scenarios reached
  cover property (tmr_irq && clean && !ctl_sh[1] && ctl_sh[6:4] != 3'h0);
  cover property (tmr_irq && ctl_sh[1] && ctl_sh[2]);
  cover property ($fell(tmr_out));
endmodule : srt_timer_monitor

bind srt_timer srt_timer_monitor u_mon (
  .clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i, .wb_adr_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .tmr_in, .tmr_out, .tmr_out_en, .tmr_irq
);

// file: verif/srt_pin_model.sv
/* Model of the GPIO pin that drives the timer input.
   Assumes the caller enters its tasks just after a rising clock edge. */
`timescale 1ns/1ps
module srt_pin_model (
  // Clock
  input wire logic clk_sys,
  // Pin
  output logic     tmr_in
);
  initial tmr_in = 1'b0;

  // Move the pin after two cycles, so no level is shorter than clk/4 allows
  task automatic park(input logic lvl);
    repeat (2) @(posedge clk_sys);
    tmr_in <= lvl;
  endtask : park

  // Full pulses away from the idle level and back
  task automatic pulses(input int n, input logic idle);
    for (int i = 0; i < n; i++) begin
      park(!idle);
      park(idle);
    end
  endtask : pulses
endmodule : srt_pin_model

// file: verif/tb_sixteen_bit_reload_timer.sv
/* Self-checking bench for the reload timer.
   Assumes srt_timer, the pin model and the bound checker are compiled first. */
`timescale 1ns/1ps
module tb_sixteen_bit_reload_timer;
  import srt_pkg::*;
  logic        clk_sys;
  logic        rst;
  srt_wb_req_t req;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        tmr_in;
  logic        tmr_out;
  logic        tmr_out_en;
  logic        tmr_irq;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cyc_cnt = 0;
  int          irq_cnt = 0;
  int          c;
  logic [15:0] v;
  logic [15:0] w;

  srt_timer dut (
    .clk_sys, .rst, .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_sel_i(req.sel),
    .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o, .wb_ack_o, .tmr_in, .tmr_out, .tmr_out_en, .tmr_irq
  );
  srt_pin_model pin (.clk_sys, .tmr_in);

  // 125 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Reload pulse count and hang guard
  always @(posedge clk_sys) begin
    cyc_cnt <= cyc_cnt + 1;
    if (tmr_irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (cyc_cnt == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (num_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t value %h expected %h", $time, got, exp);
    end
  endtask : check

  // Classic cycle, held until ack is sampled high
  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    req <= '{1'b1, 1'b1, we, 4'h1, a, {24'h0, d}};
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    req <= '0;
    @(posedge clk_sys);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    check({8'h0, q}, {8'h0, e});
  endtask : rd_chk

  // High byte first, so the low byte comes from the hold copy
  task automatic rd16(output logic [15:0] r);
    bus(1'b0, OFS_COUNT_HIGH, 8'h00, r[15:8]);
    bus(1'b0, OFS_COUNT_LOW, 8'h00, r[7:0]);
  endtask : rd16

  task automatic wait_irq(output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (tmr_irq !== 1'b1);
  endtask : wait_irq

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and an unmapped read
  task automatic t_reset();
    rd_chk(OFS_COUNT_HIGH, 8'h00);
    rd_chk(OFS_COUNT_LOW, 8'h01);
    rd_chk(OFS_RELOAD_HI, 8'hFF);
    rd_chk(OFS_RELOAD_LO, 8'hFF);
    rd_chk(OFS_CONTROL, 8'h00);
    rd_chk(8'h18, 8'h00);
  endtask : t_reset

  // Loaded start, restart at one, prescaled period with reads in between
  task automatic t_cont();
    wr(OFS_COUNT_HIGH, 8'h00);
    wr(OFS_COUNT_LOW, 8'h03);
    wr(OFS_RELOAD_HI, 8'h00);
    wr(OFS_RELOAD_LO, 8'h06);
    wr(OFS_CONTROL, 8'h09);
    wait_irq(c);
    check(16'(c), 16'd4);
    check({15'h0, tmr_out}, 16'h1);
    wait_irq(c);
    check(16'(c), 16'd6);
    check({15'h0, tmr_out}, 16'h0);
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_COUNT_LOW, 8'h01);
    wr(OFS_RELOAD_LO, 8'h04);
    wr(OFS_CONTROL, 8'h29);
    wait_irq(c);
    rd16(v);
    wait_irq(c);
    check(16'(c), 16'd10);
    rd_chk(OFS_STATUS, 8'h03);
    wr(OFS_STATUS, 8'h01);
    rd_chk(OFS_STATUS, 8'h02);
  endtask : t_cont

  // Hold copy versus live byte, and a byte write while running
  task automatic t_read();
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_RELOAD_HI, 8'hFF);
    wr(OFS_RELOAD_LO, 8'hFF);
    wr(OFS_CONTROL, 8'h01);
    rd16(v);
    bus(1'b0, OFS_COUNT_HIGH, 8'h00, w[15:8]);
    repeat (5) @(posedge clk_sys);
    bus(1'b0, OFS_COUNT_LOW, 8'h00, w[7:0]);
    check(w - v, 16'd6);
    wr(OFS_COUNT_LOW, 8'h80);
    rd16(v);
    check(v, 16'h0082);
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_COUNT_LOW, 8'h5A);
    rd_chk(OFS_COUNT_LOW, 8'h5A);
  endtask : t_read

  // Counter mode with the largest prescale; a wrong edge would give count 3 too
  task automatic t_counter(input logic pol);
    int i0;
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_COUNT_LOW, 8'h01);
    wr(OFS_RELOAD_HI, 8'h00);
    wr(OFS_RELOAD_LO, 8'h03);
    pin.park(pol);
    repeat (8) @(posedge clk_sys);
    wr(OFS_CONTROL, {4'b0111, 1'b0, pol, 2'b11});
    i0 = irq_cnt;
    pin.pulses(2, pol);
    pin.park(!pol);
    pin.park(pol);
    repeat (8) @(posedge clk_sys);
    check(16'(irq_cnt - i0), 16'd0);
    rd16(v);
    check(v, 16'h0003);
    pin.pulses(1, pol);
    repeat (8) @(posedge clk_sys);
    check(16'(irq_cnt - i0), 16'd1);
    rd16(v);
    check(v, 16'h0001);
  endtask : t_counter

  ////////////////////////////////////////////////////////////////////////////
  // Reset for two cycles, then the scenarios
  initial begin
    rst = 1'b1;
    req = '0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_cont();
    t_read();
    t_counter(1'b0);
    t_counter(1'b1);
    finish_test();
  end
endmodule : tb_sixteen_bit_reload_timer
